// [logic/ufc_params.svh]
// Constants for the serial channel FIFO control block
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH

`define UFC_ADDR_W 5
`define UFC_OFF_FIFO_CTRL 5'h00
`define UFC_OFF_IRQ_STAT 5'h04
`define UFC_OFF_IRQ_MASK 5'h08
`define UFC_OFF_FIFO_STAT 5'h0C

`define UFC_BIT_SOFT_RST 15
`define UFC_RX_LVL_HI 8
`define UFC_RX_LVL_LO 7
`define UFC_TX_LVL_HI 4
`define UFC_TX_LVL_LO 3
`define UFC_BIT_TX_CLR 2
`define UFC_BIT_RX_CLR 1
`define UFC_BIT_CLR_EN 0
`define UFC_CTRL_RESET 9'h000

`define UFC_SOFT_RST_CYCLES 3'h4
`define UFC_FIFO_DEPTH 2'h2

`define UFC_IRQ_RX_REQ 0
`define UFC_IRQ_TX_REQ 1
`define UFC_IRQ_SOFT_DONE 2
`define UFC_IRQ_W 3

`define UFC_RESP_OKAY 2'h0
`define UFC_RESP_SLVERR 2'h2

`endif

// [logic/ufc_pkg.sv]
// Types for the serial channel FIFO control block
package ufc_pkg;
   typedef enum logic [1:0] {
      UFC_LVL_ONE = 2'b00,
      UFC_LVL_TWO = 2'b01
   } ufc_level_t;
   typedef enum logic [0:0] {
      UFC_RUN = 1'b0,
      UFC_SOFT_RST = 1'b1
   } ufc_state_t;
endpackage

// [logic/ufc_fifo_ctrl.sv]
// FIFO control register, channel soft reset and request levels
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_params.svh"
// What this block does
// RULE1: Writing one to soft reset bit resets channel for exactly 4 clocks.
// RULE2: During soft reset every register access and transfer request is ignored; here bus accesses stall until the reset ends instead.
// RULE3: Host spaces its next channel write after a soft reset by several cycles.
// RULE4: Receive level field 8:7 selects request at one (00) or two (01) bytes.
// RULE5: Transmit level field 4:3 selects request at one (00) or two (01) bytes.
// RULE6: Transmit clear bit 2 empties transmit FIFO only with enable bit set.
// RULE7: Receive clear bit 1 empties receive FIFO only with enable bit set.
// RULE8: Enable bit 0 low blocks both FIFO clears; high allows them.
// RULE9: Host sets enable in the same write as a clear bit.
// RULE10: A FIFO clear holds while its bit and enable stay one.
// RULE11: Soft reset acts regardless of the enable bit.
// RULE12: Receive FIFO holds at most two entries, count zero to two.
// RULE13: Unused bits read zero, ignore writes, all fields reset to zero.
module ufc_fifo_ctrl
   import ufc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // AXI4-Lite slave
   input wire logic [`UFC_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [`UFC_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Fill levels from the channel FIFOs
   input wire logic [1:0] rx_fill_count_i,
   input wire logic [1:0] tx_fill_count_i,
   // Controls to the channel
   output logic channel_soft_reset_o,
   output logic tx_fifo_clear_o,
   output logic rx_fifo_clear_o,
   output logic rx_request_o,
   output logic tx_request_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [1:0] rx_request_level_r;
   logic [1:0] tx_request_level_r;
   logic tx_fifo_clear_r;
   logic rx_fifo_clear_r;
   logic fifo_clear_enable_r;
   ufc_state_t state_r;
   logic [2:0] rst_cnt_r;
   logic [`UFC_IRQ_W-1:0] irq_stat_r;
   logic [`UFC_IRQ_W-1:0] irq_mask_r;
   logic aw_held_r;
   logic [`UFC_ADDR_W-1:0] awaddr_r;
   logic w_held_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   wire in_reset = (state_r == UFC_SOFT_RST);
   // Stalling the bus while the channel is down keeps requests pending, not lost
   assign s_axi_awready_o = !aw_held_r && !bvalid_r && !in_reset; // RULE2
   assign s_axi_wready_o = !w_held_r && !bvalid_r && !in_reset; // RULE2
   assign s_axi_arready_o = !rvalid_r && !in_reset; // RULE2
   wire aw_fire = s_axi_awvalid_i && s_axi_awready_o;
   wire w_fire = s_axi_wvalid_i && s_axi_wready_o;
   wire ar_fire = s_axi_arvalid_i && s_axi_arready_o;
   wire aw_have = aw_held_r || aw_fire;
   wire w_have = w_held_r || w_fire;
   wire wr_go = aw_have && w_have && !in_reset;
   wire [`UFC_ADDR_W-1:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr_i;
   wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata_i;
   wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb_i;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   wire wr_ctrl = wr_go && (wr_addr == `UFC_OFF_FIFO_CTRL);
   wire wr_stat = wr_go && (wr_addr == `UFC_OFF_IRQ_STAT);
   wire wr_mask = wr_go && (wr_addr == `UFC_OFF_IRQ_MASK);
   wire wr_known = wr_ctrl || wr_stat || wr_mask || (wr_addr == `UFC_OFF_FIFO_STAT);
   wire wr_lo = wr_ctrl && wr_strb[0];
   wire wr_hi = wr_ctrl && wr_strb[1];
   wire soft_go = wr_hi && wr_data[`UFC_BIT_SOFT_RST]; // RULE1 RULE11
   wire [`UFC_IRQ_W-1:0] stat_clr = wr_stat && wr_strb[0] ? wr_data[`UFC_IRQ_W-1:0] : 3'h0;

   // ----------------------------------------------------------------
   // Requests and events
   // ----------------------------------------------------------------
   wire [1:0] rx_need = (rx_request_level_r == UFC_LVL_TWO) ? `UFC_FIFO_DEPTH : 2'h1; // RULE4
   wire [1:0] tx_need = (tx_request_level_r == UFC_LVL_TWO) ? `UFC_FIFO_DEPTH : 2'h1; // RULE5
   // Invalid level codes fall back to the one-byte threshold
   wire rx_req = !in_reset && (rx_fill_count_i >= rx_need); // RULE4 RULE12
   wire tx_req = !in_reset && (tx_fill_count_i >= tx_need); // RULE5
   wire soft_done = in_reset && (rst_cnt_r == 3'h1);
   wire [`UFC_IRQ_W-1:0] irq_evt = {soft_done, tx_req, rx_req};
   assign rx_request_o = rx_req;
   assign tx_request_o = tx_req;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_request_level_r <= 2'h0; // RULE13
         tx_request_level_r <= 2'h0;
         tx_fifo_clear_r <= 1'b0;
         rx_fifo_clear_r <= 1'b0;
         fifo_clear_enable_r <= 1'b0;
      end else if (soft_go || in_reset) begin
         // Soft reset returns the control register fields to their reset values; interrupt status and mask keep theirs
         rx_request_level_r <= 2'h0; // RULE1
         tx_request_level_r <= 2'h0;
         tx_fifo_clear_r <= 1'b0;
         rx_fifo_clear_r <= 1'b0;
         fifo_clear_enable_r <= 1'b0;
      end else begin
         if (wr_hi) begin
            rx_request_level_r[1] <= wr_data[`UFC_RX_LVL_HI];
         end
         if (wr_lo) begin
            rx_request_level_r[0] <= wr_data[`UFC_RX_LVL_LO];
            tx_request_level_r <= wr_data[`UFC_TX_LVL_HI:`UFC_TX_LVL_LO];
            tx_fifo_clear_r <= wr_data[`UFC_BIT_TX_CLR];
            rx_fifo_clear_r <= wr_data[`UFC_BIT_RX_CLR];
            fifo_clear_enable_r <= wr_data[`UFC_BIT_CLR_EN];
         end
      end
   end

   assign tx_fifo_clear_o = tx_fifo_clear_r && fifo_clear_enable_r; // RULE6 RULE8 RULE10
   assign rx_fifo_clear_o = rx_fifo_clear_r && fifo_clear_enable_r; // RULE7 RULE8 RULE10
   assign channel_soft_reset_o = in_reset; // RULE1

   // ----------------------------------------------------------------
   // Soft reset sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= UFC_RUN;
         rst_cnt_r <= 3'h0;
      end else begin
         case (state_r)
            UFC_RUN: begin
               if (soft_go) begin
                  state_r <= UFC_SOFT_RST; // RULE1
                  rst_cnt_r <= `UFC_SOFT_RST_CYCLES;
               end
            end
            UFC_SOFT_RST: begin
               rst_cnt_r <= rst_cnt_r - 3'h1;
               if (rst_cnt_r == 3'h1) begin
                  state_r <= UFC_RUN;
               end
            end
            default: begin
               state_r <= UFC_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_stat_r <= 3'h0;
         irq_mask_r <= 3'h0;
      end else begin
         // A new event outranks a clear in the same cycle
         irq_stat_r <= (irq_stat_r & ~stat_clr) | irq_evt;
         if (wr_mask && wr_strb[0]) begin
            irq_mask_r <= wr_data[`UFC_IRQ_W-1:0];
         end
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   // ----------------------------------------------------------------
   // Write channel holding and response
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_held_r <= 1'b0;
         awaddr_r <= 5'h00;
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
      end else begin
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_known ? `UFC_RESP_OKAY : `UFC_RESP_SLVERR;
         end else begin
            if (aw_fire) begin
               aw_held_r <= 1'b1;
               awaddr_r <= s_axi_awaddr_i;
            end
            if (w_fire) begin
               w_held_r <= 1'b1;
               wdata_r <= s_axi_wdata_i;
               wstrb_r <= s_axi_wstrb_i;
            end
            if (bvalid_r && s_axi_bready_i) begin
               bvalid_r <= 1'b0;
            end
         end
      end
   end

   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;

   // ----------------------------------------------------------------
   // Read decode and response
   // ----------------------------------------------------------------
   // Bits 15:9 read as zero; the soft reset bit is write-only
   wire [31:0] ctrl_view = {16'h0000, 7'h00, rx_request_level_r, 2'h0, tx_request_level_r,
                            tx_fifo_clear_r, rx_fifo_clear_r, fifo_clear_enable_r}; // RULE13
   wire [31:0] fill_view = {28'h0000000, tx_fill_count_i, rx_fill_count_i};
   wire rd_ctrl = (s_axi_araddr_i == `UFC_OFF_FIFO_CTRL);
   wire rd_stat = (s_axi_araddr_i == `UFC_OFF_IRQ_STAT);
   wire rd_mask = (s_axi_araddr_i == `UFC_OFF_IRQ_MASK);
   wire rd_fill = (s_axi_araddr_i == `UFC_OFF_FIFO_STAT);
   wire rd_known = rd_ctrl || rd_stat || rd_mask || rd_fill;
   wire [31:0] rd_val = rd_ctrl ? ctrl_view :
                        rd_stat ? {29'h0000000, irq_stat_r} :
                        rd_mask ? {29'h0000000, irq_mask_r} :
                        rd_fill ? fill_view : 32'h0000_0000;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= 2'h0;
      end else if (ar_fire) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= rd_known ? `UFC_RESP_OKAY : `UFC_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready_i) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;

endmodule
`default_nettype wire

// [verif/ufc_fill_model.sv]
// Fill-count model of the channel FIFOs facing the control block
`timescale 1ns/1ps
`default_nettype none
module ufc_fill_model (
   // Clock, reset and controls from the block
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic channel_soft_reset_i,
   input wire logic rx_fifo_clear_i,
   input wire logic tx_fifo_clear_i,
   // Fill wanted by the bench
   input wire logic [1:0] rx_want_i,
   input wire logic [1:0] tx_want_i,
   // Counts to the block
   output logic [1:0] rx_fill_count_o,
   output logic [1:0] tx_fill_count_o
);
   // Counts follow the wish one cycle late; clears force empty
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i || channel_soft_reset_i) begin
         rx_fill_count_o <= 2'h0;
         tx_fill_count_o <= 2'h0;
      end else begin
         rx_fill_count_o <= rx_fifo_clear_i ? 2'h0 : rx_want_i;
         tx_fill_count_o <= tx_fifo_clear_i ? 2'h0 : tx_want_i;
      end
   end
endmodule
`default_nettype wire

// [verif/ufc_fifo_ctrl_chk.sv]
// Port-level checker for the FIFO control block
`timescale 1ns/1ps
`default_nettype none
`include "ufc_params.svh"
module ufc_fifo_ctrl_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [`UFC_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_arready_o, channel_soft_reset_o, rx_fifo_clear_o,
   input wire logic tx_fifo_clear_o, rx_request_o, tx_request_o,
   input wire logic [1:0] rx_fill_count_i,
   input wire logic [1:0] tx_fill_count_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      && s_axi_awaddr_i == 5'h00;
   srst_len_a: assert property ($rose(channel_soft_reset_o) |->
      channel_soft_reset_o[*4] ##1 !channel_soft_reset_o) else $error("soft reset length");
   srst_start_a: assert property (wr_go && s_axi_wstrb_i[1] && s_axi_wdata_i[15]
      |=> $rose(channel_soft_reset_o)) else $error("soft reset not started");
   srst_block_a: assert property (channel_soft_reset_o |->
      !(s_axi_awready_o || s_axi_wready_o || s_axi_arready_o)) else $error("bus taken");
   req_quiet_a: assert property (channel_soft_reset_o |->
      !(rx_request_o || tx_request_o)) else $error("request in soft reset");
   clr_block_a: assert property (wr_go && s_axi_wstrb_i[0] && !s_axi_wdata_i[0]
      |=> !(rx_fifo_clear_o || tx_fifo_clear_o)) else $error("clear not blocked");
   rx_clr_a: assert property (wr_go && s_axi_wstrb_i == 4'h1 && s_axi_wdata_i[1:0] == 2'h3
      |=> rx_fifo_clear_o) else $error("rx clear missing");
   tx_clr_a: assert property (wr_go && s_axi_wstrb_i == 4'h1 && s_axi_wdata_i[2:0] == 3'h5
      |=> tx_fifo_clear_o) else $error("tx clear missing");
   clr_hold_a: assert property (rx_fifo_clear_o && !(s_axi_awvalid_i && s_axi_awready_o)
      |=> rx_fifo_clear_o) else $error("rx clear dropped");
   rx_full_a: assert property (rx_fill_count_i == 2'h2 && !channel_soft_reset_o
      |-> rx_request_o) else $error("rx request missing");
   tx_full_a: assert property (tx_fill_count_i == 2'h2 && !channel_soft_reset_o
      |-> tx_request_o) else $error("tx request missing");
endmodule
`default_nettype wire

// [verif/tb_uart_fifo_control.sv]
// Self-checking bench for the FIFO control block
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_control;
   logic clk_i = 0, rst_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
   logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, s_axi_awready_o, s_axi_wready_o;
   logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, channel_soft_reset_o;
   logic tx_fifo_clear_o, rx_fifo_clear_o, rx_request_o, tx_request_o, irq_o;
   logic [4:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
   logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, rd;
   logic [3:0] s_axi_wstrb_i = 0;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rr, rx_fill_count_i, tx_fill_count_i;
   logic [1:0] rx_want = 0, tx_want = 0;
   int n_mismatch = 0, tests_run = 0;
   always #12.5 clk_i = ~clk_i;
   ufc_fifo_ctrl dut_u (.*);
   ufc_fill_model far_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .channel_soft_reset_i(channel_soft_reset_o), .rx_fifo_clear_i(rx_fifo_clear_o),
      .tx_fifo_clear_i(tx_fifo_clear_o), .rx_want_i(rx_want), .tx_want_i(tx_want),
      .rx_fill_count_o(rx_fill_count_i), .tx_fill_count_o(tx_fill_count_i));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("mismatches=%0d checks=%0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Stalls during soft reset are legal, so the bound is generous
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (!s_axi_bvalid_o && n < 40);
      // bready stays high; a following call drives it high again at its start
      if (n >= 40) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   task automatic axi_rd(input logic [4:0] a);
      int n;
      n = 0;
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (!s_axi_rvalid_o && n < 40);
      rd = s_axi_rdata_o;
      rr = s_axi_rresp_o;
      if (n >= 40) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_regs;
      axi_rd(5'h00);
      chk(rd, 32'h0);
      axi_wr(5'h00, 32'hFFFF7FF8, 4'hF);
      axi_rd(5'h00);
      chk(rd, 32'h198);
      axi_rd(5'h10);
      chk(rd, 32'h0);
      chk(rr, 2'h2);
   endtask
   // Invalid level codes behave as the one-byte level
   task t_levels;
      rx_want <= 2'h1;
      tx_want <= 2'h1;
      for (int c = 0; c < 4; c++) begin
         axi_wr(5'h00, (c << 7) | (c << 3), 4'h3);
         repeat (2) @(posedge clk_i);
         chk(rx_request_o, c != 1);
         chk(tx_request_o, c != 1);
      end
      axi_wr(5'h00, 32'h88, 4'h3);
      rx_want <= 2'h2;
      tx_want <= 2'h2;
      repeat (2) @(posedge clk_i);
      chk({rx_request_o, tx_request_o}, 2'b11);
   endtask
   task t_clear;
      axi_wr(5'h00, 32'h6, 4'h1);
      chk({rx_fifo_clear_o, tx_fifo_clear_o}, 2'b00);
      axi_wr(5'h00, 32'h3, 4'h1);
      @(posedge clk_i);
      chk({rx_fifo_clear_o, tx_fifo_clear_o, rx_fill_count_i}, 4'b1000);
      axi_wr(5'h00, 32'h7, 4'h1);
      chk({rx_fifo_clear_o, tx_fifo_clear_o}, 2'b11);
      axi_wr(5'h00, 32'h5, 4'h1);
      chk({rx_fifo_clear_o, tx_fifo_clear_o}, 2'b01);
      axi_wr(5'h00, 32'h0, 4'h1);
      chk({rx_fifo_clear_o, tx_fifo_clear_o}, 2'b00);
   endtask
   task t_srst;
      int n;
      n = 0;
      // Load every field except the transmit clear bit first so the soft reset has something to clear
      axi_wr(5'h00, 32'h0000019B, 4'h3);
      axi_rd(5'h00);
      chk(rd, 32'h19B);
      axi_wr(5'h00, 32'h8000, 4'h2);
      while (channel_soft_reset_o && n < 10) begin
         n++;
         chk(s_axi_arready_o, 1'b0);
         @(posedge clk_i);
      end
      chk(n, 4);
      repeat (2) @(posedge clk_i);
      axi_rd(5'h00);
      chk(rd, 32'h0);
      chk(irq_o, 1'b0);
      axi_wr(5'h08, 32'h4, 4'h1);
      chk(irq_o, 1'b1);
      axi_wr(5'h04, 32'h4, 4'h1);
      chk(irq_o, 1'b0);
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      t_levels();
      t_clear();
      t_srst();
      wrap_up();
   end
endmodule
bind ufc_fifo_ctrl ufc_fifo_ctrl_chk chk_u (.*);
`default_nettype wire
